// ==== src/add_group_pkg.sv ====
// Purpose: shared constants for the add-group execute block
// Assumes: 64-bit datapath, little-endian memory only
// Notes: opcodes and access-type codes are named once here
package add_group_pkg;
	localparam int XLEN = 64;
	localparam int PADDR_W = 32;
	// instruction fields
	localparam int OPC_LSB = 26;
	localparam int RS_LSB = 21;
	localparam int RT_LSB = 16;
	localparam int RD_LSB = 11;
	// decode values
	localparam logic [5:0] OPC_REGISTER = 6'h00;
	localparam logic [5:0] FN_ADD_TRAPPING = 6'h20;
	localparam logic [5:0] FN_ADD_WRAPPING = 6'h21;
	localparam logic [5:0] OPC_ADD_IMMEDIATE_TRAPPING = 6'h08;
	localparam logic [5:0] OPC_ADD_IMMEDIATE_WRAPPING = 6'h09;
	// access type codes: bytes moved minus one
	localparam logic [2:0] ACC_BYTE = 3'h0;
	localparam logic [2:0] ACC_HALF = 3'h1;
	localparam logic [2:0] ACC_WORD = 3'h3;
	localparam logic [2:0] ACC_DOUBLE = 3'h7;
	// byte order is fixed little-endian, reverse-endian never set
	localparam logic BIG_ENDIAN_CPU = 1'b0;
	localparam logic [4:0] LINK_REGISTER = 5'h1f;
	// exception causes reported on exc_code
	localparam logic [2:0] EXC_NONE = 3'h0;
	localparam logic [2:0] EXC_OVERFLOW = 3'h1;
	localparam logic [2:0] EXC_TRANSLATION = 3'h2;
	localparam logic [2:0] EXC_FETCH_ALIGN = 3'h3;
	localparam logic [2:0] EXC_EXTERNAL = 3'h4;
	typedef enum logic [1:0] {
		LS_IDLE = 2'b00,
		LS_WAIT = 2'b01
	} ls_state_t;
endpackage

// ==== src/add_unit.sv ====
// Purpose: 32-bit add with sign extension and overflow flag
// Assumes: operands are sign-extended 32-bit values
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps
module add_unit import add_group_pkg::*; (
	input wire logic [XLEN-1:0] op_a,
	input wire logic [XLEN-1:0] op_b,
	output logic [XLEN-1:0] sum_ext,
	output logic overflow
);
	logic [32:0] sum33;
	logic carry_into_31;

	// only the low word takes part; upper bits of bad operands are ignored
	assign sum33 = {1'b0, op_a[31:0]} + {1'b0, op_b[31:0]};
	assign carry_into_31 = op_a[31] ^ op_b[31] ^ sum33[31];
	// carry out of bit 30 versus carry out of bit 31
	assign overflow = carry_into_31 ^ sum33[32];
	// replicate bit 31 into the upper word
	assign sum_ext = {{32{sum33[31]}}, sum33[31:0]};
endmodule

// ==== src/add_group_exec.sv ====
// Purpose: execute stage for the add family, load/store issue and delay-slot tracking
// Assumes: one instruction in execute per cycle; inputs synchronous to ref_clk
// Notes: an exception squashes the execute-stage write; branch-in-slot goes unchecked
//
// How it works
// - a load's consumer right behind it stalls until the loaded data returns
// - access type code is byte count minus one, 0 through 7
// - the address names the lowest byte; little-endian puts it least significant
// - byte lanes come only from access type and physical address bits 2..0
// - every jump and branch has exactly one delay slot that always executes
// - a branch in a delay slot is not detected; its outcome is undefined
// - exception in a delay slot saves the branch address as return address
// - returning restarts at the branch, re-running branch and delay slot
// - misaligned register-jump target faults when that target is fetched
// - control coprocessor registers are reached only by move-to and move-from
// - trapping register add sums two registers; overflow when carries 30 and 31 differ
// - an overflowing trapping add leaves the destination unchanged and traps
// - add result is a 32-bit sum sign-extended to 64 bits
// - badly sign-extended add operands give an undefined result
// - immediate adds sign-extend the 16-bit field and write the rt field
// - wrapping adds do the same arithmetic but never trap
// - load or store without a translation entry faults and skips memory
// - cacheable load fetches and fills the whole word, then picks the bytes
// - byte order is fixed little-endian; reverse-endian is not offered
`timescale 1ns/1ps
module add_group_exec import add_group_pkg::*; #(
	parameter int VA_W = XLEN
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic ex_valid,
	input wire logic [31:0] ex_instr,
	input wire logic [VA_W-1:0] ex_pc,
	input wire logic [XLEN-1:0] rs_value,
	input wire logic [XLEN-1:0] rt_value,
	input wire logic ex_is_branch,
	input wire logic ex_branch_taken,
	input wire logic ex_is_reg_jump,
	input wire logic [VA_W-1:0] ex_branch_target,
	input wire logic compressed_mode,
	input wire logic ext_exception,
	input wire logic exception_return,
	input wire logic fetch_valid,
	input wire logic [VA_W-1:0] fetch_pc,
	input wire logic id_valid,
	input wire logic [4:0] id_rs,
	input wire logic [4:0] id_rt,
	input wire logic ls_valid,
	input wire logic ls_store,
	input wire logic [2:0] ls_type,
	input wire logic [4:0] ls_dest,
	input wire logic [XLEN-1:0] ls_wdata,
	input wire logic tlb_hit,
	input wire logic tlb_cacheable,
	input wire logic [PADDR_W-1:0] tlb_paddr,
	input wire logic mem_rvalid,
	input wire logic [XLEN-1:0] mem_rdata,
	input wire logic cop_move_to,
	input wire logic cop_move_from,
	input wire logic cop_mem_form,
	input wire logic [4:0] cop_reg,
	output logic wb_we_reg,
	output logic [4:0] wb_dst_reg,
	output logic [XLEN-1:0] wb_data_reg,
	output logic stall_reg,
	output logic mem_req_reg,
	output logic mem_we_reg,
	output logic mem_fill_reg,
	output logic [2:0] mem_type_reg,
	output logic [PADDR_W-1:0] mem_paddr_reg,
	output logic [7:0] mem_lanes_reg,
	output logic [XLEN-1:0] mem_wdata_reg,
	output logic load_done_reg,
	output logic [4:0] load_dst_reg,
	output logic [XLEN-1:0] load_data_reg,
	output logic exc_taken_reg,
	output logic [2:0] exc_code_reg,
	output logic [VA_W-1:0] exception_return_address_reg,
	output logic redirect_reg,
	output logic [VA_W-1:0] redirect_pc_reg,
	output logic sys_ctrl_we_reg,
	output logic sys_ctrl_re_reg,
	output logic [4:0] sys_ctrl_idx_reg
);
	if (VA_W < 32 || VA_W > XLEN)
		$error("VA_W must lie between 32 and XLEN");
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////////////
	logic [5:0] opc, fn;
	logic is_reg_add, is_imm_add, add_traps, add_ovf, ovf_trap;
	logic [XLEN-1:0] add_b, add_sum;
	logic [4:0] add_dst;
	assign opc = ex_instr[OPC_LSB +: 6];
	assign fn = ex_instr[5:0];
	// register adds use the register opcode and function field
	assign is_reg_add = opc == OPC_REGISTER
		&& (fn == FN_ADD_TRAPPING || fn == FN_ADD_WRAPPING);
	assign is_imm_add = opc == OPC_ADD_IMMEDIATE_TRAPPING
		|| opc == OPC_ADD_IMMEDIATE_WRAPPING;
	// only the two trapping forms may raise overflow
	assign add_traps = (is_reg_add && fn == FN_ADD_TRAPPING)
		|| (!is_reg_add && opc == OPC_ADD_IMMEDIATE_TRAPPING);
	// immediate sign-extended to full width
	assign add_b = is_imm_add ? {{(XLEN-16){ex_instr[15]}}, ex_instr[15:0]} : rt_value;
	// immediate forms write rt, register forms write rd
	assign add_dst = is_imm_add ? ex_instr[RT_LSB +: 5] : ex_instr[RD_LSB +: 5];
	add_unit u_add (
		.op_a(rs_value),
		.op_b(add_b),
		.sum_ext(add_sum),
		.overflow(add_ovf)
	);
	assign ovf_trap = ex_valid && (is_reg_add || is_imm_add) && add_traps && add_ovf;
	////////////////////////////////////////////////////////////////////////
	logic [2:0] offs;
	logic [3:0] size_bytes;
	logic [15:0] lane_wide;
	logic [7:0] lanes;
	logic ls_fault, ls_go;
	assign offs = tlb_paddr[2:0];
	assign size_bytes = {1'b0, ls_type} + 4'h1;
	// lowest lane is the addressed byte; fixed little-endian
	assign lane_wide = ((16'h0001 << size_bytes) - 16'h0001) << offs;
	assign lanes = lane_wide[7:0];
	assign ls_fault = ex_valid && ls_valid && !tlb_hit;
	assign ls_go = ex_valid && ls_valid && tlb_hit;
	ls_state_t ls_state_reg;
	logic [2:0] ld_offs_reg, ld_type_reg;
	// one memory request per accepted load/store; a fault never reaches memory
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_req_reg <= 1'b0;
			mem_we_reg <= 1'b0;
			mem_fill_reg <= 1'b0;
			mem_type_reg <= ACC_BYTE;
			mem_paddr_reg <= '0;
			mem_lanes_reg <= 8'h00;
			mem_wdata_reg <= '0;
		end else begin
			mem_req_reg <= ls_go;
			if (ls_go) begin
				mem_we_reg <= ls_store;
				mem_type_reg <= ls_type;
				// cacheable loads pull the whole word to fill the line
				mem_fill_reg <= !ls_store && tlb_cacheable;
				mem_lanes_reg <= (!ls_store && tlb_cacheable) ? 8'hff : lanes;
				mem_paddr_reg <= tlb_paddr;
				mem_wdata_reg <= ls_wdata << {offs, 3'h0};
			end
		end
	end
	// load tracking: remember lane offset and size until data returns
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ls_state_reg <= LS_IDLE;
			ld_offs_reg <= 3'h0;
			ld_type_reg <= ACC_BYTE;
			load_dst_reg <= 5'h00;
		end else begin
			case (ls_state_reg)
				LS_IDLE: begin
					if (ls_go && !ls_store) begin
						ls_state_reg <= LS_WAIT;
						ld_offs_reg <= offs;
						ld_type_reg <= ls_type;
						load_dst_reg <= ls_dest;
					end
				end
				LS_WAIT: begin
					if (mem_rvalid)
						ls_state_reg <= LS_IDLE;
				end
				default: ls_state_reg <= LS_IDLE;
			endcase
		end
	end
	// pick the requested bytes, least significant first
	logic [XLEN-1:0] shifted, picked;
	assign shifted = mem_rdata >> {ld_offs_reg, 3'h0};
	for (genvar gb = 0; gb < 8; gb++) begin : g_pick
		assign picked[gb*8 +: 8] = (gb <= ld_type_reg) ? shifted[gb*8 +: 8] : 8'h00;
	end
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			load_done_reg <= 1'b0;
			load_data_reg <= '0;
		end else begin
			load_done_reg <= ls_state_reg == LS_WAIT && mem_rvalid;
			if (ls_state_reg == LS_WAIT && mem_rvalid)
				load_data_reg <= picked;
		end
	end
	// interlock: hold decode while its source is an outstanding load
	logic load_busy_next, stall_next;
	logic [4:0] busy_dst;
	assign load_busy_next = (ls_state_reg == LS_WAIT && !mem_rvalid) || (ls_go && !ls_store);
	assign busy_dst = (ls_state_reg == LS_WAIT) ? load_dst_reg : ls_dest;
	assign stall_next = load_busy_next && id_valid && busy_dst != 5'h00
		&& (id_rs == busy_dst || id_rt == busy_dst);
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			stall_reg <= 1'b0;
		else
			stall_reg <= stall_next;
	end
	////////////////////////////////////////////////////////////////////////
	logic in_slot_reg, bad_target_reg, misaligned, fetch_fault, any_exc;
	logic [VA_W-1:0] branch_pc_reg, bad_pc_reg;
	logic [2:0] exc_code_next;
	// word-aligned targets, half-word in the compressed mode
	assign misaligned = compressed_mode ? ex_branch_target[0] : |ex_branch_target[1:0];
	assign fetch_fault = bad_target_reg && fetch_valid && fetch_pc == bad_pc_reg;
	always_comb begin
		exc_code_next = EXC_NONE;
		if (ls_fault)
			exc_code_next = EXC_TRANSLATION;
		else if (ovf_trap)
			exc_code_next = EXC_OVERFLOW;
		else if (fetch_fault)
			exc_code_next = EXC_FETCH_ALIGN;
		else if (ex_valid && ext_exception)
			exc_code_next = EXC_EXTERNAL;
	end
	assign any_exc = exc_code_next != EXC_NONE;
	// the instruction after any jump or branch is its slot; nested branches unchecked
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			in_slot_reg <= 1'b0;
			branch_pc_reg <= '0;
		end else if (any_exc) begin
			in_slot_reg <= 1'b0;
		end else if (ex_valid) begin
			in_slot_reg <= ex_is_branch;
			if (ex_is_branch)
				branch_pc_reg <= ex_pc;
		end
	end
	// a bad register-jump target waits for its own fetch
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			bad_target_reg <= 1'b0;
			bad_pc_reg <= '0;
		end else if (ex_valid && ex_is_reg_jump && ex_branch_taken && misaligned && !any_exc) begin
			bad_target_reg <= 1'b1;
			bad_pc_reg <= ex_branch_target;
		end else if (fetch_fault || any_exc) begin
			bad_target_reg <= 1'b0;
		end
	end
	// return address points at the branch when the slot faulted
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			exc_taken_reg <= 1'b0;
			exc_code_reg <= EXC_NONE;
			exception_return_address_reg <= '0;
		end else begin
			exc_taken_reg <= any_exc;
			exc_code_reg <= exc_code_next;
			if (any_exc)
				exception_return_address_reg <= (exc_code_next == EXC_FETCH_ALIGN)
					? bad_pc_reg : (in_slot_reg ? branch_pc_reg : ex_pc);
		end
	end
	// return re-runs the branch and then its slot
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			redirect_reg <= 1'b0;
			redirect_pc_reg <= '0;
		end else begin
			redirect_reg <= exception_return && !any_exc;
			if (exception_return && !any_exc)
				redirect_pc_reg <= exception_return_address_reg;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// an overflowing trapping add leaves its destination alone
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wb_we_reg <= 1'b0;
			wb_dst_reg <= 5'h00;
			wb_data_reg <= '0;
		end else begin
			wb_we_reg <= ex_valid && (is_reg_add || is_imm_add) && !any_exc
				&& add_dst != 5'h00;
			wb_dst_reg <= add_dst;
			wb_data_reg <= add_sum;
		end
	end
	// coprocessor load/store forms are dropped; only moves touch the registers
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sys_ctrl_we_reg <= 1'b0;
			sys_ctrl_re_reg <= 1'b0;
			sys_ctrl_idx_reg <= 5'h00;
		end else begin
			sys_ctrl_we_reg <= ex_valid && cop_move_to && !cop_mem_form && !any_exc;
			sys_ctrl_re_reg <= ex_valid && cop_move_from && !cop_mem_form && !any_exc;
			sys_ctrl_idx_reg <= cop_reg;
		end
	end
	////////////////////////////////////////////////////////////////////////
	add_ovf_nowrite_a: assert property (
		ovf_trap |=> !wb_we_reg && exc_taken_reg && exc_code_reg == EXC_OVERFLOW)
		else $error("overflowing add wrote its destination");
	wrap_no_trap_a: assert property (
		ex_valid && is_reg_add && fn == FN_ADD_WRAPPING && add_dst != 5'h00 && !ls_fault
		&& !fetch_fault && !ext_exception |=> wb_we_reg)
		else $error("wrapping add did not write");
	sext_result_a: assert property (
		wb_we_reg |-> wb_data_reg[XLEN-1:32] == {(XLEN-32){wb_data_reg[31]}})
		else $error("add result not sign-extended");
	tlb_fault_a: assert property (
		ls_fault |=> !mem_req_reg && exc_code_reg == EXC_TRANSLATION)
		else $error("untranslated access reached memory");
	type_code_a: assert property (
		ls_go && !(!ls_store && tlb_cacheable) |=>
		mem_type_reg == $past(ls_type) && $countones(mem_lanes_reg) <= 32'(mem_type_reg) + 1)
		else $error("access type or lane count wrong");
	slot_epc_a: assert property (
		in_slot_reg && any_exc && !fetch_fault |=> exception_return_address_reg == $past(branch_pc_reg))
		else $error("delay-slot fault saved wrong return address");
	restart_a: assert property (
		exception_return && !any_exc |=> redirect_reg
		&& redirect_pc_reg == $past(exception_return_address_reg))
		else $error("return did not restart at saved address");
	stall_hold_a: assert property (
		ls_state_reg == LS_WAIT && !mem_rvalid && id_valid && load_dst_reg != 5'h00
		&& id_rs == load_dst_reg |=> stall_reg)
		else $error("consumer of pending load not stalled");
	late_align_a: assert property (
		ex_valid && ex_is_reg_jump && ex_branch_taken && misaligned && !any_exc
		|=> !exc_taken_reg ##0 bad_target_reg)
		else $error("misaligned jump trapped at execute");
	move_only_a: assert property (
		ex_valid && cop_mem_form |=> !sys_ctrl_we_reg && !sys_ctrl_re_reg)
		else $error("coprocessor memory form reached control registers");
endmodule

// ==== verification/tb_top.sv ====
// Purpose: self-checking bench for the add-group execute block
// Assumes: outputs registered on the same edge that samples a request
// Notes: assertions live in the design files, so this bench only drives and compares
`timescale 1ns/1ps
module tb_top import add_group_pkg::*;;

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

logic ref_clk, rst_b, ex_valid, ex_is_branch, ex_branch_taken, ex_is_reg_jump, compressed_mode;
logic ext_exception, exception_return, fetch_valid, id_valid, ls_valid, ls_store;
logic tlb_hit, tlb_cacheable, mem_rvalid, cop_move_to, cop_move_from, cop_mem_form;
logic [31:0] ex_instr, ex_pc, ex_branch_target, fetch_pc, tlb_paddr;
logic [63:0] rs_value, rt_value, ls_wdata, mem_rdata;
logic [4:0] id_rs, id_rt, ls_dest, cop_reg;
logic [2:0] ls_type;
logic wb_we_reg, stall_reg, mem_req_reg, mem_we_reg, mem_fill_reg, load_done_reg, exc_taken_reg;
logic redirect_reg, sys_ctrl_we_reg, sys_ctrl_re_reg;
logic [4:0] wb_dst_reg, load_dst_reg, sys_ctrl_idx_reg;
logic [63:0] wb_data_reg, mem_wdata_reg, load_data_reg;
logic [2:0] mem_type_reg, exc_code_reg;
logic [31:0] mem_paddr_reg, exception_return_address_reg, redirect_pc_reg;
logic [7:0] mem_lanes_reg;
int miscompares, checks, cycles;

// narrow virtual addresses keep the pc compares short
add_group_exec #(.VA_W(32)) uut (.*);

////////////////////////////////////////////////////////////////////////////////
// clock, timeout and verdict

initial begin
	ref_clk = 1'b0;
	forever #10 ref_clk = ~ref_clk;
end

// the whole run needs well under a hundred cycles; a hang ends here
always @(posedge ref_clk) begin
	cycles <= cycles + 1;
	if (cycles == 2000) begin
		miscompares++;
		close_out();
	end
end

task automatic close_out();
	if (miscompares == 0 && checks > 0)
		$display("Test passed");
	else
		$display("Test failed");
	$finish;
endtask

////////////////////////////////////////////////////////////////////////////////
// drivers: every strobe is one cycle wide unless a scenario holds it

task automatic idle();
	{ex_valid, ex_is_branch, ex_branch_taken, ex_is_reg_jump, ext_exception} <= '0;
	{exception_return, fetch_valid, ls_valid, ls_store, mem_rvalid} <= '0;
	{cop_move_to, cop_move_from, cop_mem_form} <= '0;
endtask

// lets the sampling edge pass, then waits for registered outputs to land
task automatic step();
	@(posedge ref_clk);
	idle();
	#1;
endtask

// jumps arrive pre-decoded with no register sources, so none names the link register
task automatic ex_op(input logic [31:0] pc, input logic br, input logic rj,
	input logic [31:0] tgt, input logic ext);
	@(posedge ref_clk);
	ex_valid <= 1'b1;
	ex_instr <= 32'h0;
	ex_pc <= pc;
	ex_is_branch <= br;
	ex_branch_taken <= br;
	ex_is_reg_jump <= rj;
	ex_branch_target <= tgt;
	ext_exception <= ext;
endtask

task automatic ls_op(input logic st, input logic [2:0] t, input logic [31:0] pa,
	input logic cach, input logic hit);
	@(posedge ref_clk);
	ex_valid <= 1'b1;
	ex_instr <= 32'h0;
	ls_valid <= 1'b1;
	ls_store <= st;
	ls_type <= t;
	tlb_paddr <= pa;
	tlb_cacheable <= cach;
	tlb_hit <= hit;
	ls_dest <= 5'h05;
	ls_wdata <= 64'h1122334455667788;
endtask

////////////////////////////////////////////////////////////////////////////////
// scenarios

// the sum and overflow are worked out here from the low words; the trap flag marks a trapping form
task automatic add_case(input logic [5:0] opc, input logic [5:0] fn, input logic trap,
	input logic [63:0] a, input logic [63:0] b);
	logic [63:0] bv;
	logic [31:0] s;
	logic ovf;
	bv = (opc == OPC_REGISTER) ? b : {{48{b[15]}}, b[15:0]};
	s = a[31:0] + bv[31:0];
	ovf = trap && (a[31] == bv[31]) && (s[31] != a[31]);
	@(posedge ref_clk);
	ex_valid <= 1'b1;
	ex_instr <= {opc, 5'h03, 5'h09, (opc == OPC_REGISTER) ? {5'h07, 5'h00, fn} : b[15:0]};
	rs_value <= a;
	rt_value <= (opc == OPC_REGISTER) ? b : 64'h0123456789abcdef;
	step();
	`CHK(wb_we_reg, !ovf)
	`CHK(exc_taken_reg, ovf)
	if (ovf)
		`CHK(exc_code_reg, EXC_OVERFLOW)
	else begin
		`CHK(wb_data_reg, {{32{s[31]}}, s})
		`CHK(wb_dst_reg, (opc == OPC_REGISTER) ? 5'h07 : 5'h09)
	end
endtask

task automatic check_adds();
	add_case(OPC_REGISTER, FN_ADD_TRAPPING, 1'b1, 64'h1, 64'h2);
	add_case(OPC_REGISTER, FN_ADD_TRAPPING, 1'b1, 64'h7fffffff, 64'h1);
	add_case(OPC_REGISTER, FN_ADD_WRAPPING, 1'b0, 64'h7fffffff, 64'h1);
	add_case(OPC_ADD_IMMEDIATE_TRAPPING, 6'h0, 1'b1, 64'h5, 64'hfffe);
	add_case(OPC_ADD_IMMEDIATE_TRAPPING, 6'h0, 1'b1, 64'hffffffff80000000, 64'hffff);
	add_case(OPC_ADD_IMMEDIATE_WRAPPING, 6'h0, 1'b0, 64'h7fffffff, 64'h7fff);
endtask

// every access-type code at offset 0, then a halfword in the top lanes
task automatic check_stores();
	logic [8:0] m;
	for (int t = 0; t < 8; t++) begin
		ls_op(1'b1, 3'(t), 32'h1000, 1'b0, 1'b1);
		step();
		m = (9'h002 << t) - 9'h001;
		`CHK(mem_type_reg, 3'(t))
		`CHK(mem_lanes_reg, m[7:0])
		`CHK({mem_req_reg, mem_we_reg}, 2'h3)
	end
	ls_op(1'b1, ACC_HALF, 32'h1006, 1'b0, 1'b1);
	step();
	`CHK(mem_lanes_reg, 8'hc0)
	`CHK(mem_wdata_reg, 64'h7788000000000000)
	`CHK(mem_paddr_reg, 32'h1006)
endtask

// the consumer sits in decode behind the load, so decode must hold
task automatic check_load();
	ls_op(1'b0, ACC_WORD, 32'h1004, 1'b1, 1'b1);
	id_valid <= 1'b1;
	id_rs <= 5'h05;
	step();
	`CHK({mem_req_reg, mem_we_reg, mem_fill_reg}, 3'h5)
	`CHK(mem_lanes_reg, 8'hff)
	`CHK(stall_reg, 1'b1)
	@(posedge ref_clk);
	mem_rvalid <= 1'b1;
	mem_rdata <= 64'h8899aabbccddeeff;
	step();
	`CHK(load_done_reg, 1'b1)
	`CHK(load_dst_reg, 5'h05)
	`CHK(load_data_reg, 64'h8899aabb)
	`CHK(stall_reg, 1'b0)
	@(posedge ref_clk);
	id_valid <= 1'b0;
	step();
	`CHK(stall_reg, 1'b0)
	// the second consumer reads the loaded register through its rt source
	ls_op(1'b0, ACC_BYTE, 32'h2003, 1'b0, 1'b1);
	{id_valid, id_rs, id_rt} <= {1'b1, 5'h00, 5'h05};
	step();
	`CHK({mem_fill_reg, mem_lanes_reg}, 9'h008)
	`CHK(stall_reg, 1'b1)
	@(posedge ref_clk);
	mem_rvalid <= 1'b1;
	step();
	`CHK(load_data_reg, 64'hcc)
	`CHK(stall_reg, 1'b0)
endtask

task automatic check_miss();
	ls_op(1'b0, ACC_WORD, 32'h10, 1'b1, 1'b0);
	step();
	`CHK(mem_req_reg, 1'b0)
	`CHK({exc_taken_reg, exc_code_reg}, {1'b1, EXC_TRANSLATION})
endtask

// slot fault saves the branch pc; a fault outside a slot saves its own pc
task automatic check_delay_slot();
	ex_op(32'h100, 1'b1, 1'b0, 32'h200, 1'b0);
	ex_op(32'h104, 1'b0, 1'b0, 32'h0, 1'b1);
	step();
	`CHK({exc_taken_reg, exc_code_reg}, {1'b1, EXC_EXTERNAL})
	`CHK(exception_return_address_reg, 32'h100)
	@(posedge ref_clk);
	exception_return <= 1'b1;
	step();
	`CHK({redirect_reg, redirect_pc_reg}, {1'b1, 32'h100})
	ex_op(32'h300, 1'b0, 1'b0, 32'h0, 1'b1);
	step();
	`CHK(exception_return_address_reg, 32'h300)
endtask

// a misaligned register target faults only at its fetch
task automatic check_jump_align();
	ex_op(32'h400, 1'b1, 1'b1, 32'h502, 1'b0);
	step();
	`CHK(exc_taken_reg, 1'b0)
	@(posedge ref_clk);
	fetch_valid <= 1'b1;
	fetch_pc <= 32'h502;
	step();
	`CHK({exc_taken_reg, exc_code_reg}, {1'b1, EXC_FETCH_ALIGN})
	`CHK(exception_return_address_reg, 32'h502)
	@(posedge ref_clk);
	compressed_mode <= 1'b1;
	ex_op(32'h600, 1'b1, 1'b1, 32'h602, 1'b0);
	step();
	@(posedge ref_clk);
	fetch_valid <= 1'b1;
	fetch_pc <= 32'h602;
	step();
	`CHK(exc_taken_reg, 1'b0)
endtask

task automatic check_coprocessor();
	@(posedge ref_clk);
	{ex_valid, cop_move_to, cop_reg} <= {2'h3, 5'h0c};
	step();
	`CHK({sys_ctrl_we_reg, sys_ctrl_re_reg, sys_ctrl_idx_reg}, 7'h4c)
	@(posedge ref_clk);
	{ex_valid, cop_move_from} <= 2'h3;
	step();
	`CHK({sys_ctrl_we_reg, sys_ctrl_re_reg}, 2'h1)
	@(posedge ref_clk);
	{ex_valid, cop_move_to, cop_move_from, cop_mem_form} <= 4'hf;
	step();
	`CHK({sys_ctrl_we_reg, sys_ctrl_re_reg}, 2'h0)
endtask

////////////////////////////////////////////////////////////////////////////////
// main sequence

initial begin
	rst_b = 1'b0;
	idle();
	{ex_instr, ex_pc, ex_branch_target, fetch_pc, tlb_paddr, rs_value, rt_value} <= '0;
	{ls_wdata, mem_rdata, id_rs, id_rt, ls_dest, cop_reg, ls_type} <= '0;
	{id_valid, compressed_mode, tlb_hit, tlb_cacheable} <= '0;
	repeat (3) @(posedge ref_clk);
	rst_b <= 1'b1;
	check_adds();
	check_stores();
	check_load();
	check_miss();
	check_delay_slot();
	check_coprocessor();
	check_jump_align();
	close_out();
end

endmodule
